/* shared/mais_pkg.sv */
// Constants, field layouts and carrier types of the analog input sequencer.
// Assumes a single 40 MHz clock and a classic Wishbone register port.
package mais_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Longest time one conversion may take, floor to cycles
  localparam int CONV_MAX_NS = 5000;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  // Step response budget, floor to cycles
  localparam int STEP_RESP_US = 1000;
  localparam int STEP_RESP_CYC = STEP_RESP_US * (CLK_HZ / 1_000_000);
  // Idle gap between two conversions
  localparam int CH_GAP_CYC = 16;
  localparam int NUM_CH = 8;

  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_FAULT_OFS = 8'h08;

  localparam int CTRL_COUNT_LSB = 0;
  localparam int CTRL_RANGE_BIT = 3;
  localparam int CTRL_PTR_BIT = 4;
  localparam int CTRL_RUN_BIT = 5;
  localparam logic [2:0] CTRL_COUNT_RST = 3'h7;
  localparam logic CTRL_RANGE_RST = 1'h0;
  localparam logic CTRL_PTR_RST = 1'h0;
  localparam logic CTRL_RUN_RST = 1'h1;

  localparam int STAT_SHOWN_LSB = 0;
  localparam int STAT_CONV_LSB = 4;
  localparam int STAT_POWER_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;

  localparam int FAULT_TMO_BIT = 0;
  localparam int FAULT_PWR_BIT = 1;

  typedef struct packed {
    logic diag_sign;
    logic [2:0] chan;
    logic [11:0] data;
  } mais_word_type;

  typedef struct packed {
    logic neg;
    logic [11:0] mag;
  } mais_sample_type;

  typedef struct packed {
    logic last;
    mais_word_type word;
  } mais_beat_type;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_START = 2'b01,
    CV_WAIT = 2'b10,
    CV_GAP = 2'b11
  } mais_conv_state_type;

  typedef enum logic [2:0] {
    OS_IDLE = 3'b000,
    OS_MUX_RD = 3'b001,
    OS_MUX_WR = 3'b010,
    OS_PTR_RD = 3'b011,
    OS_PTR_PUSH = 3'b100
  } mais_out_state_type;

  // Channel after ch, wrapping past the last active one
  function automatic logic [2:0] mais_next_chan(input logic [2:0] ch, input logic [2:0] cnt);
    mais_next_chan = (ch >= cnt) ? 3'h0 : 3'(ch + 3'h1);
  endfunction : mais_next_chan

  function automatic logic mais_is_last(input logic [2:0] ch, input logic [2:0] cnt);
    mais_is_last = (ch >= cnt);
  endfunction : mais_is_last
endpackage : mais_pkg

/* hw/mais_sample_mem.sv */
// Small result store: one write port, one read port with registered data.
// Assumes both ports run on the same clock; a same-cycle read sees the old word.
`timescale 1ns/1ps
`default_nettype none
module mais_sample_mem #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("mais_sample_mem: bad size");
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule : mais_sample_mem
`default_nettype wire

/* hw/mais_buf.sv */
// Small FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset; drain side may stall freely.
`timescale 1ns/1ps
`default_nettype none
module mais_buf #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] fill_ff;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("mais_buf: DEPTH must be a power of two, at least 2");
  end

  assign in_ready_o = (fill_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (fill_ff != '0);
  assign out_data_o = slot_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      slot_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      fill_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
      end
      if (pop) begin
        rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
      end
      if (push && !pop) begin
        fill_ff <= (AW+1)'(fill_ff + 1'b1);
      end else if (pop && !push) begin
        fill_ff <= (AW+1)'(fill_ff - 1'b1);
      end
    end
  end
endmodule : mais_buf
`default_nettype wire

/* hw/mais_top.sv */
// Eight-channel analog input sequencer: converts channels in the background
// and hands one channel per host scan, or all active channels at once as a stream.
// Assumes a converter that answers a start pulse with a done pulse and sample,
// a host that pulses scan_strobe_i once per scan, and a Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module mais_top
  import mais_pkg::*;
#(
  parameter int STEP_CYC = STEP_RESP_CYC,
  parameter int CONV_CYC = CONV_MAX_CYC,
  parameter int GAP_CYC = CH_GAP_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic adc_start_o,
  output logic [2:0] adc_chan_o,
  output logic adc_range_5v_o,
  input wire logic adc_done_i,
  input wire mais_sample_type adc_sample_i,
  input wire logic field_power_ok_i,
  input wire logic scan_strobe_i,
  output mais_word_type in_word_o,
  output mais_beat_type ptr_beat_o,
  output logic ptr_valid_o,
  input wire logic ptr_ready_i
);
  localparam int TW = 16;

  // Full pass over eight channels must fit the step response budget
  // pass time check
  if (NUM_CH * (CONV_CYC + GAP_CYC + 2) > STEP_CYC || CONV_CYC < 1 || GAP_CYC < 1
      || CONV_CYC >= (1 << TW) || GAP_CYC >= (1 << TW)) begin : g_chk
    $error("mais_top: timing parameters cannot meet the step response");
  end

  logic [2:0] count_sel_ff;
  logic range_select_link_ff;
  logic ptr_mode_ff;
  logic run_ff;
  logic tmo_fault_ff;
  logic pwr_fault_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;

  mais_conv_state_type conv_state_ff;
  mais_conv_state_type nxt_conv_state;
  logic [2:0] conv_ch_ff;
  logic [TW-1:0] timer_ff;
  logic mem_wr_en;
  logic conv_timeout;

  mais_out_state_type out_state_ff;
  mais_out_state_type nxt_out_state;
  logic [2:0] shown_ch_ff;
  logic [2:0] burst_ch_ff;
  logic [2:0] rd_addr;
  mais_sample_type rd_sample;
  mais_word_type word_ff;
  mais_word_type built_word;
  logic [2:0] eff_ch;
  logic buf_in_ready;
  logic buf_push;

  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_ofs;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_ofs = {wb_adr_i[7:2], 2'b00};
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;

  // Register port: answers every address one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
    end else begin
      wb_ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_ff <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      case (wb_ofs)
        REG_CTRL_OFS: begin
          wb_dat_ff <= {26'h0, run_ff, ptr_mode_ff, range_select_link_ff, count_sel_ff};
        end
        REG_STATUS_OFS: begin
          wb_dat_ff <= {22'h0, (out_state_ff != OS_IDLE), field_power_ok_i, 1'b0, conv_ch_ff,
                        1'b0, shown_ch_ff};
        end
        REG_FAULT_OFS: begin
          wb_dat_ff <= {30'h0, pwr_fault_ff, tmo_fault_ff};
        end
        default: begin
          wb_dat_ff <= 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_sel_ff <= CTRL_COUNT_RST;
      range_select_link_ff <= CTRL_RANGE_RST;
      ptr_mode_ff <= CTRL_PTR_RST;
      run_ff <= CTRL_RUN_RST;
    end else if (wb_wr && wb_ofs == REG_CTRL_OFS) begin
      count_sel_ff <= wb_dat_i[CTRL_COUNT_LSB +: 3];
      range_select_link_ff <= wb_dat_i[CTRL_RANGE_BIT];
      ptr_mode_ff <= wb_dat_i[CTRL_PTR_BIT];
      run_ff <= wb_dat_i[CTRL_RUN_BIT];
    end
  end

  assign adc_range_5v_o = range_select_link_ff;

  // Sticky faults, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_fault_ff <= 1'b0;
      pwr_fault_ff <= 1'b0;
    end else begin
      if (conv_timeout) begin
        tmo_fault_ff <= 1'b1;
      end else if (wb_wr && wb_ofs == REG_FAULT_OFS && wb_dat_i[FAULT_TMO_BIT]) begin
        tmo_fault_ff <= 1'b0;
      end
      if (!field_power_ok_i) begin
        pwr_fault_ff <= 1'b1;
      end else if (wb_wr && wb_ofs == REG_FAULT_OFS && wb_dat_i[FAULT_PWR_BIT]) begin
        pwr_fault_ff <= 1'b0;
      end
    end
  end

  // Background conversion, free of the host scan
  // continuous conversion loop
  always_comb begin
    nxt_conv_state = conv_state_ff;
    case (conv_state_ff)
      CV_IDLE: begin
        if (run_ff) begin
          nxt_conv_state = CV_START;
        end
      end
      CV_START: begin
        nxt_conv_state = CV_WAIT;
      end
      CV_WAIT: begin
        if (adc_done_i || conv_timeout) begin
          nxt_conv_state = CV_GAP;
        end
      end
      CV_GAP: begin
        if (timer_ff == TW'(GAP_CYC - 1)) begin
          nxt_conv_state = run_ff ? CV_START : CV_IDLE;
        end
      end
      default: begin
        nxt_conv_state = CV_IDLE;
      end
    endcase
  end

  assign conv_timeout = (conv_state_ff == CV_WAIT) && !adc_done_i && (timer_ff == TW'(CONV_CYC - 1));
  assign mem_wr_en = (conv_state_ff == CV_WAIT) && adc_done_i;
  assign adc_start_o = (conv_state_ff == CV_START);
  assign adc_chan_o = conv_ch_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_state_ff <= CV_IDLE;
    end else begin
      conv_state_ff <= nxt_conv_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ff <= '0;
    end else if (conv_state_ff != nxt_conv_state) begin
      timer_ff <= '0;
    end else begin
      timer_ff <= TW'(timer_ff + 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_ch_ff <= 3'h0;
    end else if (conv_state_ff == CV_GAP && nxt_conv_state != CV_GAP) begin
      conv_ch_ff <= mais_next_chan(conv_ch_ff, count_sel_ff);
    end
  end

  mais_sample_mem #(
    .WIDTH($bits(mais_sample_type)),
    .DEPTH(NUM_CH)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(mem_wr_en),
    .wr_addr_i(conv_ch_ff),
    .wr_data_i(adc_sample_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_sample)
  );

  // Host side: word changes only on a scan strobe
  assign eff_ch = (shown_ch_ff > count_sel_ff) ? 3'h0 : shown_ch_ff;
  assign rd_addr = (out_state_ff == OS_PTR_RD || out_state_ff == OS_PTR_PUSH) ? burst_ch_ff : eff_ch;

  // zero data with top bit marks lost field power
  always_comb begin
    built_word.chan = rd_addr;
    if (!field_power_ok_i) begin
      built_word.diag_sign = 1'b1;
      built_word.data = 12'h000;
    end else begin
      built_word.diag_sign = rd_sample.neg && (rd_sample.mag != 12'h000);
      built_word.data = rd_sample.mag;
    end
  end

  // Strobes that come while busy are ignored
  // pointer mode bursts all active channels, 0 through count_sel_ff
  always_comb begin
    nxt_out_state = out_state_ff;
    case (out_state_ff)
      OS_IDLE: begin
        if (scan_strobe_i) begin
          nxt_out_state = ptr_mode_ff ? OS_PTR_RD : OS_MUX_RD;
        end
      end
      OS_MUX_RD: begin
        nxt_out_state = OS_MUX_WR;
      end
      OS_MUX_WR: begin
        nxt_out_state = OS_IDLE;
      end
      OS_PTR_RD: begin
        nxt_out_state = OS_PTR_PUSH;
      end
      OS_PTR_PUSH: begin
        if (buf_in_ready) begin
          nxt_out_state = mais_is_last(burst_ch_ff, count_sel_ff) ? OS_IDLE : OS_PTR_RD;
        end
      end
      default: begin
        nxt_out_state = OS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_state_ff <= OS_IDLE;
    end else begin
      out_state_ff <= nxt_out_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shown_ch_ff <= 3'h0;
    end else if (out_state_ff == OS_MUX_WR) begin
      shown_ch_ff <= mais_next_chan(eff_ch, count_sel_ff);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff <= '0;
    end else if (out_state_ff == OS_MUX_WR) begin
      word_ff <= built_word;
    end
  end

  assign in_word_o = word_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_ch_ff <= 3'h0;
    end else if (out_state_ff == OS_IDLE) begin
      burst_ch_ff <= 3'h0;
    end else if (out_state_ff == OS_PTR_PUSH && buf_in_ready) begin
      burst_ch_ff <= mais_next_chan(burst_ch_ff, count_sel_ff);
    end
  end

  // Receiver stall holds the burst, no word dropped
  assign buf_push = (out_state_ff == OS_PTR_PUSH);

  mais_buf #(
    .WIDTH($bits(mais_beat_type)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(buf_push),
    .in_ready_o(buf_in_ready),
    .in_data_i({mais_is_last(burst_ch_ff, count_sel_ff), built_word}),
    .out_valid_o(ptr_valid_o),
    .out_ready_i(ptr_ready_i),
    .out_data_o(ptr_beat_o)
  );
endmodule : mais_top
`default_nettype wire

/* verification/mais_adc_model.sv */
// Converter model: one done pulse and sample per start pulse.
// Assumes the sequencer clock; the sample lines wander when no result is offered.
`timescale 1ns/1ps
`default_nettype none
module mais_adc_model
  import mais_pkg::*;
#(
  parameter int DLY = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  output logic done_o,
  output mais_sample_type sample_o
);
  int cnt_ff;
  logic [2:0] chan_ff;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    sample_o <= ~sample_o;
    if (rst_i) begin
      cnt_ff <= 0;
      sample_o <= '0;
    end else if (start_i) begin
      cnt_ff <= DLY;
      chan_ff <= chan_i;
    end else if (cnt_ff == 1) begin
      cnt_ff <= 0;
      done_o <= 1'b1;
      // Channel 3 reads negative
      sample_o <= {chan_ff == 3'h3, 8'h5A, 1'b0, chan_ff};
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : mais_adc_model
`default_nettype wire

/* verification/mais_top_asserts.sv */
// Port checker of the sequencer top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mais_top_asserts
  import mais_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic adc_start_o,
  input wire logic [2:0] adc_chan_o,
  input wire logic adc_range_5v_o,
  input wire logic field_power_ok_i,
  input wire logic scan_strobe_i,
  input wire mais_word_type in_word_o,
  input wire mais_beat_type ptr_beat_o,
  input wire logic ptr_valid_o,
  input wire logic ptr_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single pulse");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h2 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_START_GAP: assert property (adc_start_o |=> !adc_start_o [*8]) else $error("starts too close");
  AST_CHAN_STABLE: assert property (adc_start_o |=> $stable(adc_chan_o) [*8]) else $error("chan moved");
  AST_WORD_SCAN: assert property ($changed(in_word_o) && field_power_ok_i && $past(field_power_ok_i) |->
    $past(scan_strobe_i, 3) || $past(scan_strobe_i, 4)) else $error("word changed off scan");
  AST_SIGN_DIAG: assert property ($changed(in_word_o) && in_word_o.diag_sign && in_word_o.data == 12'h000 |->
    !($past(field_power_ok_i) && $past(field_power_ok_i, 2) && $past(field_power_ok_i, 3)))
    else $error("diag bit with power present");
  AST_PTR_HOLD: assert property (ptr_valid_o && !ptr_ready_i |=> ptr_valid_o && $stable(ptr_beat_o))
    else $error("beat dropped in stall");
  cover property (ptr_valid_o && ptr_ready_i && ptr_beat_o.last);
  cover property (in_word_o.diag_sign && in_word_o.data == 12'h000);
  cover property (adc_range_5v_o && adc_start_o);
endmodule : mais_top_asserts
bind mais_top mais_top_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_start_o(adc_start_o),
  .adc_chan_o(adc_chan_o), .adc_range_5v_o(adc_range_5v_o), .field_power_ok_i(field_power_ok_i),
  .scan_strobe_i(scan_strobe_i), .in_word_o(in_word_o), .ptr_beat_o(ptr_beat_o), .ptr_valid_o(ptr_valid_o),
  .ptr_ready_i(ptr_ready_i));
`default_nettype wire

/* verification/mais_top_bench.sv */
// Self-checking bench of the sequencer top.
// Assumes the converter model answers every start; host scans come from here.
`timescale 1ns/1ps
`default_nettype none
module mais_top_bench
  import mais_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, strobe = 1'b0, pwr_ok = 1'b1, rdy = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, bus_rd;
  logic adc_start, adc_done, range5, ptr_valid, ack;
  logic [2:0] adc_chan;
  mais_sample_type sample;
  mais_word_type word;
  mais_beat_type beat;
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  mais_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_start_o(adc_start),
    .adc_chan_o(adc_chan), .adc_range_5v_o(range5), .adc_done_i(adc_done), .adc_sample_i(sample),
    .field_power_ok_i(pwr_ok), .scan_strobe_i(strobe), .in_word_o(word), .ptr_beat_o(beat),
    .ptr_valid_o(ptr_valid), .ptr_ready_i(rdy));
  mais_adc_model adc_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(adc_start), .chan_i(adc_chan),
    .done_o(adc_done), .sample_o(sample));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 40);
    bus_rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 40) begin
      error_cnt++;
      end_sim();
    end
    @(posedge clk_i);
  endtask : wb
  task automatic scan(input logic [15:0] exp, input logic [15:0] mask);
    strobe <= 1'b1;
    @(posedge clk_i);
    strobe <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("in_word", {16'h0, exp}, {16'h0, word & mask});
  endtask : scan
  function automatic logic [15:0] exp_w(input logic [2:0] k);
    exp_w = {k == 3'h3, k, 8'h5A, 1'b0, k};
  endfunction : exp_w
  task automatic t_mux();
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk("ctrl reset", 32'h27, bus_rd);
    repeat (300) @(posedge clk_i);
    for (int i = 0; i < 10; i++) scan(exp_w(3'(i % 8)), 16'hFFFF);
  endtask : t_mux
  task automatic t_count();
    int bad;
    bad = 0;
    wb(1'b1, 8'h00, 32'h22, 4'hF);
    for (int i = 0; i < 4; i++) scan(exp_w(3'((i + 2) % 3)), 16'hFFFF);
    repeat (30) @(posedge clk_i);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      if (adc_start === 1'b1 && adc_chan > 3'h2) bad++;
    end
    chk("skipped chans", 32'h0, 32'(bad));
    wb(1'b1, 8'h00, 32'h21, 4'hF);
    for (int i = 0; i < 4; i++) scan(exp_w(3'(i % 2)), 16'hFFFF);
  endtask : t_count
  task automatic t_range();
    wb(1'b1, 8'h00, 32'h29, 4'hF);
    chk("range 5v", 32'h1, {31'h0, range5});
    // Writes without byte 0 must be dropped
    wb(1'b1, 8'h00, 32'h0, 4'h0);
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk("ctrl kept", 32'h29, bus_rd);
    wb(1'b1, 8'h00, 32'h27, 4'hF);
    chk("range 10v", 32'h0, {31'h0, range5});
  endtask : t_range
  task automatic t_ptr();
    int n;
    n = 0;
    wb(1'b1, 8'h00, 32'h37, 4'hF);
    rdy <= 1'b0;
    // Word keeps the last multiplexed value while bursting
    scan(exp_w(3'h1), 16'hFFFF);
    repeat (20) @(posedge clk_i);
    chk("held valid", 32'h1, {31'h0, ptr_valid});
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("busy in burst", 32'h1 << STAT_BUSY_BIT, bus_rd & (32'h1 << STAT_BUSY_BIT));
    for (int i = 0; i < 100 && n < 8; i++) begin
      @(posedge clk_i);
      if (ptr_valid === 1'b1 && rdy === 1'b1) begin
        chk("beat", {15'h0, n == 7, exp_w(3'(n))}, {15'h0, beat});
        n++;
      end
      rdy <= ~rdy;
    end
    chk("beats", 32'h8, 32'(n));
    // Loop just toggled ready in this step
    @(posedge clk_i);
    rdy <= 1'b1;
    wb(1'b1, 8'h00, 32'h27, 4'hF);
  endtask : t_ptr
  task automatic t_power();
    int bad;
    bad = 0;
    pwr_ok <= 1'b0;
    repeat (10) @(posedge clk_i);
    scan(16'h8000, 16'h8FFF);
    wb(1'b0, 8'h08, 32'h0, 4'hF);
    chk("fault set", 32'h2, bus_rd);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("status power lost", 32'h0, bus_rd & (32'h1 << STAT_POWER_BIT));
    pwr_ok <= 1'b1;
    repeat (5) @(posedge clk_i);
    wb(1'b1, 8'h08, 32'h2, 4'hF);
    wb(1'b0, 8'h08, 32'h0, 4'hF);
    chk("fault clear", 32'h0, bus_rd);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("status power ok", 32'h1 << STAT_POWER_BIT, bus_rd & (32'h1 << STAT_POWER_BIT));
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    chk("unmapped", 32'h0, bus_rd);
    // Run cleared: converter idles once the channel in flight ends
    wb(1'b1, 8'h00, 32'h07, 4'hF);
    repeat (40) @(posedge clk_i);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (adc_start === 1'b1) bad++;
    end
    chk("halted starts", 32'h0, 32'(bad));
  endtask : t_power
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_mux();
    t_count();
    t_range();
    t_ptr();
    t_power();
    end_sim();
  end
endmodule : mais_top_bench
`default_nettype wire
